// >>> hdl/plc_port_link_control_reg.sv
// Port link control register with its controls toward the link training logic.
`timescale 1ns/1ps
`include "plc_defs.svh"

// How it works
// RL1: Bits 1:0 select power-state entry: off, L0s, L1, or both.
// RL2: The power-state field resets to off; an initial load may replace it.
// RL3: Bit 3 always reads zero and ignores writes.
// RL4: On a downstream port, bit 4 set holds the link disabled.
// RL5: On the upstream port, bit 4 never disables the link.
// RL6: Writing one to bit 5 sends the training logic into Recovery.
// RL7: Bit 5 always reads back as zero.
// RL8: Fields written with a retrain request take effect in that retraining.
// RL9: Upstream port with unlock clear: bit 5 acts as zero, no retraining.
// RL10: Upstream port with unlock set: writing one to bit 5 retrains.
// RL11: Bit 6 is read-write and records a shared reference clock.
// RL12: Bit 7 set requests extra ordered sets on L0s exit and in Recovery.
// RL13: Bit 8 reads zero since reference clock removal is unsupported.
// RL14: Bit 2 and bits 15:9 read zero and ignore writes.
module plc_port_link_control_reg (
    input wire logic ref_clk_i,                         // Core clock, 20 MHz.
    input wire logic srst_i,                            // Synchronous reset, high.
    input wire plc_pkg::plc_bus_req_s req_i,            // Register bus request.
    output logic [`PLC_DATA_W-1:0] rdata_o,             // Read data, cycle after read.
    input wire logic is_upstream_i,                     // High on the upstream port.
    input wire logic global_register_unlock_i,          // Unlock level from switch control.
    input wire logic init_load_i,                       // One-cycle initial field load.
    input wire logic [1:0] init_aspm_i,                 // Power-state value to load.
    output plc_pkg::plc_link_ctl_s ctl_o                // Controls toward link training.
);
    import plc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic wr_hit;
    logic rd_hit;
    logic retrain_ok;

    assign wr_hit = req_i.wr && (req_i.addr == `PLC_LCTL_OFF);
    assign rd_hit = req_i.rd && (req_i.addr == `PLC_LCTL_OFF);
    // Upstream retraining is withheld unless the switch-wide unlock is set.
    assign retrain_ok = !is_upstream_i || global_register_unlock_i; // RL9 RL10

    ////////////////////////////////////////////////////////////////////////////
    // Stored fields.

    plc_aspm_e aspm_reg;
    plc_aspm_e aspm_next;
    logic link_off_reg;
    logic link_off_next;
    logic link_gate_reg;
    logic refclk_reg;
    logic refclk_next;
    logic ext_sync_reg;
    logic ext_sync_next;
    logic retrain_reg;
    logic retrain_next;

    // A bus write wins over an initial load arriving in the same cycle, so
    // software never sees its own value silently replaced.
    always_comb begin
        aspm_next = aspm_reg;
        if (wr_hit) begin
            aspm_next = plc_aspm_e'(req_i.wdata[`PLC_ASPM_MSB:`PLC_ASPM_LSB]); // RL1
        end else if (init_load_i) begin
            aspm_next = plc_aspm_e'(init_aspm_i); // RL2
        end
    end

    always_comb begin
        link_off_next = link_off_reg;
        refclk_next = refclk_reg;
        ext_sync_next = ext_sync_reg;
        if (wr_hit) begin
            link_off_next = req_i.wdata[`PLC_LINK_OFF_BIT];
            refclk_next = req_i.wdata[`PLC_REFCLK_BIT]; // RL11
            ext_sync_next = req_i.wdata[`PLC_EXT_SYNC_BIT]; // RL12
        end
    end

    assign retrain_next = wr_hit && req_i.wdata[`PLC_RETRAIN_BIT] && retrain_ok; // RL6

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aspm_reg <= PLC_ASPM_OFF; // RL2
        end else begin
            aspm_reg <= aspm_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link_off_reg <= `PLC_BIT_RST;
            link_gate_reg <= `PLC_BIT_RST;
        end else begin
            link_off_reg <= link_off_next;
            // The gated copy moves on the same edge as the stored bit.
            link_gate_reg <= link_off_next && !is_upstream_i; // RL4 RL5
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            refclk_reg <= `PLC_BIT_RST;
            ext_sync_reg <= `PLC_BIT_RST;
        end else begin
            refclk_reg <= refclk_next;
            ext_sync_reg <= ext_sync_next;
        end
    end

    // The retrain pulse rises on the same edge that stores the other fields,
    // so the training logic sees the new settings with the request.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            retrain_reg <= `PLC_BIT_RST;
        end else begin
            retrain_reg <= retrain_next; // RL8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [`PLC_DATA_W-1:0] rd_value;
    logic [`PLC_DATA_W-1:0] rdata_reg;
    logic [`PLC_DATA_W-1:0] rdata_next;

    always_comb begin
        rd_value = `PLC_RDATA_RST; // RL14
        rd_value[`PLC_ASPM_MSB:`PLC_ASPM_LSB] = aspm_reg;
        rd_value[`PLC_RD_BOUND_BIT] = 1'b0; // RL3
        rd_value[`PLC_LINK_OFF_BIT] = link_off_reg;
        rd_value[`PLC_RETRAIN_BIT] = 1'b0; // RL7
        rd_value[`PLC_REFCLK_BIT] = refclk_reg;
        rd_value[`PLC_EXT_SYNC_BIT] = ext_sync_reg;
        rd_value[`PLC_CLKPM_BIT] = 1'b0; // RL13
    end

    // Unmapped reads and idle cycles return zero.
    assign rdata_next = rd_hit ? rd_value : `PLC_RDATA_RST;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_reg <= `PLC_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Controls toward link training.

    assign ctl_o.l0s_enable = aspm_reg[0]; // RL1
    assign ctl_o.l1_enable = aspm_reg[1]; // RL1
    assign ctl_o.link_off = link_gate_reg;
    assign ctl_o.shared_refclk_config = refclk_reg;
    assign ctl_o.extended_sync = ext_sync_reg; // RL12
    assign ctl_o.retrain_request = retrain_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence write_s;
        wr_hit;
    endsequence

    sequence read_s;
        rd_hit;
    endsequence

    sequence retrain_write_s;
        wr_hit && req_i.wdata[`PLC_RETRAIN_BIT];
    endsequence

    sequence one_pulse_s;
        ctl_o.retrain_request ##1 !ctl_o.retrain_request;
    endsequence

    sequence locked_write_s;
        wr_hit && is_upstream_i && !global_register_unlock_i;
    endsequence

    sequence quiet_s;
        !wr_hit && !init_load_i;
    endsequence

    aspm_write_a: assert property ( // RL1
        write_s |=> aspm_reg == $past(req_i.wdata[1:0])
            && ctl_o.l0s_enable == aspm_reg[0] && ctl_o.l1_enable == aspm_reg[1])
        else $error("power-state field not taken from write");

    aspm_reset_a: assert property ( // RL2
        $fell(srst_i) |-> aspm_reg == PLC_ASPM_OFF && !ctl_o.l0s_enable
            && !ctl_o.l1_enable)
        else $error("power-state field not off after reset");

    aspm_load_a: assert property ( // RL2
        init_load_i && !wr_hit |=> aspm_reg == $past(init_aspm_i))
        else $error("initial load did not replace power-state field");

    rd_bound_zero_a: assert property ( // RL3
        read_s |=> !rdata_o[`PLC_RD_BOUND_BIT])
        else $error("completion boundary bit read as one");

    link_off_down_a: assert property ( // RL4
        !is_upstream_i && $past(!is_upstream_i) |-> ctl_o.link_off == link_off_reg)
        else $error("downstream link disable does not follow stored bit");

    link_off_up_a: assert property ( // RL5
        is_upstream_i && $past(is_upstream_i) |-> !ctl_o.link_off)
        else $error("upstream link disabled");

    // A second retrain write straight behind the first legally stretches the pulse.
    retrain_start_a: assert property ( // RL6
        retrain_write_s ##0 !is_upstream_i ##1 !(wr_hit && req_i.wdata[`PLC_RETRAIN_BIT])
            |-> one_pulse_s)
        else $error("retrain write gave no single pulse");

    retrain_read_a: assert property ( // RL7
        read_s |=> !rdata_o[`PLC_RETRAIN_BIT])
        else $error("retrain bit read as one");

    retrain_fields_a: assert property ( // RL8
        ctl_o.retrain_request |-> aspm_reg == $past(req_i.wdata[1:0])
            && ext_sync_reg == $past(req_i.wdata[7])
            && refclk_reg == $past(req_i.wdata[6]))
        else $error("retrain pulse ahead of its fields");

    retrain_locked_a: assert property ( // RL9
        write_s ##0 is_upstream_i && !global_register_unlock_i
            |=> !ctl_o.retrain_request)
        else $error("locked upstream port retrained");

    retrain_unlock_a: assert property ( // RL10
        retrain_write_s ##0 (is_upstream_i && global_register_unlock_i)
            ##1 !(wr_hit && req_i.wdata[`PLC_RETRAIN_BIT]) |-> one_pulse_s)
        else $error("unlocked upstream port did not retrain");

    retrain_cause_a: assert property ( // RL6
        ctl_o.retrain_request |-> $past(wr_hit) && $past(retrain_ok))
        else $error("retrain pulse without a write");

    refclk_write_a: assert property ( // RL11
        write_s |=> ctl_o.shared_refclk_config == $past(req_i.wdata[6]))
        else $error("shared clock bit not taken from write");

    ext_sync_write_a: assert property ( // RL12
        write_s |=> ctl_o.extended_sync == $past(req_i.wdata[7]))
        else $error("extended sync bit not taken from write");

    clkpm_zero_a: assert property ( // RL13
        read_s |=> !rdata_o[`PLC_CLKPM_BIT])
        else $error("clock removal enable read as one");

    reserved_zero_a: assert property ( // RL14
        read_s |=> rdata_o[15:9] == 7'h00 && !rdata_o[`PLC_RSVD2_BIT])
        else $error("reserved bits read as one");

    read_echo_a: assert property (
        write_s ##1 read_s |=> rdata_o[7:6] == $past(req_i.wdata[7:6], 2)
            && rdata_o[4] == $past(req_i.wdata[4], 2))
        else $error("read after write returned stale fields");

    read_idle_a: assert property (
        !rd_hit |=> rdata_o == 16'h0000)
        else $error("read data outside its cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Field holding and readback.

    reset_clear_a: assert property ( // RL2
        $fell(srst_i) |-> ctl_o == '0 && rdata_o == `PLC_RDATA_RST)
        else $error("outputs not clear after reset");

    aspm_hold_a: assert property ( // RL1
        quiet_s |=> $stable(aspm_reg))
        else $error("power-state field moved without a write or load");

    aspm_read_a: assert property ( // RL1
        read_s ##0 !init_load_i |=> rdata_o[1:0] == {ctl_o.l1_enable, ctl_o.l0s_enable})
        else $error("power-state readback differs from its outputs");

    link_off_store_a: assert property ( // RL4
        write_s |=> link_off_reg == $past(req_i.wdata[`PLC_LINK_OFF_BIT]))
        else $error("link-off bit not taken from write");

    link_off_write_a: assert property ( // RL4
        write_s ##0 !is_upstream_i
            |=> ctl_o.link_off == $past(req_i.wdata[`PLC_LINK_OFF_BIT]))
        else $error("downstream link disable not taken from write");

    link_off_hold_a: assert property ( // RL4
        !wr_hit && $stable(is_upstream_i) |=> $stable(ctl_o.link_off))
        else $error("link disable moved without a write");

    link_off_read_a: assert property ( // RL4
        read_s |=> rdata_o[`PLC_LINK_OFF_BIT] == link_off_reg)
        else $error("link-off readback differs from stored bit");

    link_off_up_write_a: assert property ( // RL5
        write_s ##0 is_upstream_i |=> !ctl_o.link_off)
        else $error("write disabled the upstream link");

    retrain_again_a: assert property ( // RL6
        retrain_write_s ##0 !is_upstream_i ##1 retrain_write_s ##0 !is_upstream_i
            |-> ctl_o.retrain_request [*2])
        else $error("back-to-back retrain writes gave no two-cycle pulse");

    retrain_after_a: assert property ( // RL7
        retrain_write_s ##1 read_s |=> !rdata_o[`PLC_RETRAIN_BIT])
        else $error("retrain bit read back as written");

    locked_fields_a: assert property ( // RL9
        locked_write_s |=> !ctl_o.retrain_request
            && ctl_o.extended_sync == $past(req_i.wdata[`PLC_EXT_SYNC_BIT])
            && ctl_o.shared_refclk_config == $past(req_i.wdata[`PLC_REFCLK_BIT]))
        else $error("locked retrain write dropped its other fields");

    refclk_hold_a: assert property ( // RL11
        !wr_hit |=> $stable(ctl_o.shared_refclk_config))
        else $error("shared clock bit moved without a write");

    refclk_read_a: assert property ( // RL11
        read_s |=> rdata_o[`PLC_REFCLK_BIT] == ctl_o.shared_refclk_config)
        else $error("shared clock readback differs from its output");

    ext_sync_hold_a: assert property ( // RL12
        !wr_hit |=> $stable(ctl_o.extended_sync))
        else $error("extended sync bit moved without a write");

    ext_sync_read_a: assert property ( // RL12
        read_s |=> rdata_o[`PLC_EXT_SYNC_BIT] == ctl_o.extended_sync)
        else $error("extended sync readback differs from its output");

    rd_bound_write_a: assert property ( // RL3
        write_s ##0 req_i.wdata[`PLC_RD_BOUND_BIT] ##1 read_s |=> !rdata_o[`PLC_RD_BOUND_BIT])
        else $error("completion boundary bit kept a written one");

    clkpm_write_a: assert property ( // RL13
        write_s ##0 req_i.wdata[`PLC_CLKPM_BIT] ##1 read_s |=> !rdata_o[`PLC_CLKPM_BIT])
        else $error("clock removal enable kept a written one");

    reserved_write_a: assert property ( // RL14
        write_s ##0 (req_i.wdata[15:9] != 7'h00) ##1 read_s
            |=> rdata_o[15:9] == 7'h00 && !rdata_o[`PLC_RSVD2_BIT])
        else $error("reserved bits kept a written one");

    unmapped_write_a: assert property (
        req_i.wr && (req_i.addr != `PLC_LCTL_OFF) && !init_load_i
            |=> $stable(aspm_reg) && $stable(link_off_reg) && !ctl_o.retrain_request
            && $stable(ctl_o.shared_refclk_config) && $stable(ctl_o.extended_sync))
        else $error("write to another address changed the register");

endmodule : plc_port_link_control_reg

// >>> hdl/plc_defs.svh
// Offsets, field positions and reset values of the port link control register.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

`define PLC_ADDR_W 12
`define PLC_DATA_W 16
`define PLC_LCTL_OFF 12'h050

`define PLC_ASPM_LSB 0
`define PLC_ASPM_MSB 1
`define PLC_RSVD2_BIT 2
`define PLC_RD_BOUND_BIT 3
`define PLC_LINK_OFF_BIT 4
`define PLC_RETRAIN_BIT 5
`define PLC_REFCLK_BIT 6
`define PLC_EXT_SYNC_BIT 7
`define PLC_CLKPM_BIT 8
`define PLC_RSVD_HI_LSB 9
`define PLC_RSVD_HI_MSB 15

`define PLC_ASPM_RST 2'h0
`define PLC_BIT_RST 1'h0
`define PLC_RDATA_RST 16'h0000

`endif

// >>> hdl/plc_pkg.sv
// Types shared by the port link control register bank.
`include "plc_defs.svh"

package plc_pkg;

    typedef enum logic [1:0] {
        PLC_ASPM_OFF = 2'b00,
        PLC_ASPM_L0S = 2'b01,
        PLC_ASPM_L1 = 2'b10,
        PLC_ASPM_BOTH = 2'b11
    } plc_aspm_e;

    typedef struct packed {
        logic [`PLC_ADDR_W-1:0] addr;
        logic [`PLC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } plc_bus_req_s;

    typedef struct packed {
        logic l0s_enable;
        logic l1_enable;
        logic link_off;
        logic shared_refclk_config;
        logic extended_sync;
        logic retrain_request;
    } plc_link_ctl_s;

endpackage : plc_pkg

// >>> test/tb.sv
// Self-checking testbench for the port link control register.
`timescale 1ns/1ps
`include "plc_defs.svh"

module tb;
    import plc_pkg::*;

    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    plc_bus_req_s req = '0;
    logic [15:0] rdata_o;
    logic up = 1'b0;
    logic unlock = 1'b0;
    logic init_load = 1'b0;
    logic [1:0] init_aspm = 2'h0;
    plc_link_ctl_s ctl_o;
    logic [15:0] exp_reg = 16'h0000;
    int fail_count = 0;
    int cmp_count = 0;
    int seed = 32'hEF6D;

    always #25 ref_clk_i = ~ref_clk_i;

    plc_port_link_control_reg DUT (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .req_i(req),
        .rdata_o(rdata_o),
        .is_upstream_i(up),
        .global_register_unlock_i(unlock),
        .init_load_i(init_load),
        .init_aspm_i(init_aspm),
        .ctl_o(ctl_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_ctl(input logic [15:0] r, input logic p);
        exp_ctl = {10'h000, r[0], r[1], r[4] & ~up, r[6], r[7], p};
    endfunction : exp_ctl

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Holding reset for two edges also lets the port direction change safely.
    task automatic do_reset(input logic to_up);
        srst_i <= 1'b1;
        up <= to_up;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        exp_reg = 16'h0000;
        #1;
        chk("ctl_reset", {10'h000, ctl_o}, 16'h0000);
        chk("rdata_reset", rdata_o, 16'h0000);
    endtask : do_reset

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic p;
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
        p = (a == `PLC_LCTL_OFF) && d[5] && (!up || unlock);
        if (a == `PLC_LCTL_OFF) exp_reg = d & 16'h00D3;
        #1;
        chk("ctl_wr", {10'h000, ctl_o}, exp_ctl(exp_reg, p));
        chk("rdata_idle", rdata_o, 16'h0000);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        #1;
        chk("rdata", rdata_o, (a == `PLC_LCTL_OFF) ? exp_reg : 16'h0000);
        chk("ctl_rd", {10'h000, ctl_o}, exp_ctl(exp_reg, 1'b0));
    endtask : rd

    task automatic rnd(input int n);
        logic [15:0] d;
        logic [11:0] a;
        for (int i = 0; i < n; i++) begin
            d = 16'($random(seed));
            a = ($random(seed) & 3) ? `PLC_LCTL_OFF : 12'($random(seed));
            unlock <= 1'($random(seed));
            if (d[15] && d[14]) rd(a);
            else wr(a, d);
        end
    endtask : rnd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(4000 * 50);
        fail_count++;
        give_verdict();
    end

    initial begin
        do_reset(1'b0);
        rd(`PLC_LCTL_OFF);
        // Every power-state code, with all other bits set so fixed bits are exercised.
        for (int i = 0; i < 4; i++) begin
            wr(`PLC_LCTL_OFF, 16'hFFFC | 16'(i));
            rd(`PLC_LCTL_OFF);
        end
        wr(`PLC_LCTL_OFF, 16'h0000);
        wr(`PLC_LCTL_OFF, 16'h0020);
        wr(`PLC_LCTL_OFF, 16'h0030);
        rd(`PLC_LCTL_OFF);
        $display("test downstream fields done");
        init_aspm <= 2'h2;
        init_load <= 1'b1;
        @(posedge ref_clk_i);
        init_load <= 1'b0;
        exp_reg[1:0] = 2'h2;
        #1;
        chk("ctl_load", {10'h000, ctl_o}, exp_ctl(exp_reg, 1'b0));
        rd(`PLC_LCTL_OFF);
        // A bus write in the same cycle as a load must win.
        init_aspm <= 2'h1;
        init_load <= 1'b1;
        wr(`PLC_LCTL_OFF, 16'h0003);
        init_load <= 1'b0;
        rd(`PLC_LCTL_OFF);
        wr(12'h052, 16'hFFFF);
        rd(12'h052);
        rd(`PLC_LCTL_OFF);
        $display("test load and unmapped done");
        rnd(150);
        $display("test downstream random done");
        unlock <= 1'b0;
        do_reset(1'b1);
        wr(`PLC_LCTL_OFF, 16'h00F3);
        rd(`PLC_LCTL_OFF);
        unlock <= 1'b1;
        wr(`PLC_LCTL_OFF, 16'h0020);
        rd(`PLC_LCTL_OFF);
        rnd(150);
        $display("test upstream done");
        give_verdict();
    end
endmodule : tb
